// >>> bench/exec_checker_assertions.sv
// Checker: timing and flag properties of the execute datapath
`default_nettype none
module exec_checker
   import exec_pkg::*;
#(
   parameter int DW = DATA_W
)
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic instr_valid,
   input wire instr_t instr,
   input wire logic [PC_W-1:0] stack_top,
   input wire logic irq_pending,
   input wire logic wake,
   input wire logic [DW-1:0] working_register,
   input wire logic mem_we,
   input wire flags_t flags,
   input wire logic [PC_W-1:0] pc,
   input wire logic stack_pop,
   input wire logic master_interrupt_enable,
   input wire logic power_down_flag,
   input wire logic watchdog_timeout_flag,
   input wire logic watchdog_clear,
   input wire logic sys_clk_gate_off,
   input wire logic dummy_cycle,
   input wire logic irq_vector_take
);
   logic tk;
   assign tk = instr_valid && !dummy_cycle && !sys_clk_gate_off;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   a_jump_dummy: assert property (tk && instr.op == jump_op |=>
      dummy_cycle && pc == $past(instr.addr) ##1 !dummy_cycle) else $error("jump timing wrong");
   a_dummy_refuse: assert property (dummy_cycle |=>
      $stable(working_register) && !mem_we && !stack_pop) else $error("dummy cycle not idle");
   a_exit_pop: assert property (tk && instr.op inside {subroutine_exit_op, subroutine_exit_imm_op} |=>
      stack_pop && pc == $past(stack_top)) else $error("exit did not pop");
   a_irq_resume: assert property (tk && instr.op == interrupt_exit_op |=>
      master_interrupt_enable && irq_vector_take == $past(irq_pending)) else $error("interrupt exit wrong");
   a_halt_entry: assert property (tk && instr.op == power_down_op |=>
      sys_clk_gate_off && power_down_flag && watchdog_clear && !watchdog_timeout_flag) else $error("halt entry wrong");
   a_halt_hold: assert property (sys_clk_gate_off && !wake |=>
      sys_clk_gate_off && $stable(pc) && $stable(working_register)) else $error("state moved while halted");
   a_rot_flags: assert property (tk && instr.op inside {rotate_left_op, rotate_left_to_w_op,
      rotate_right_op, rotate_right_to_w_op} |=> $stable(flags)) else $error("rotate changed flags");
   a_cpl_zero: assert property (tk && instr.op == complement_to_w_op |=> !mem_we &&
      working_register == ~$past(instr.mem_data) && flags.zero_flag == (working_register == 0))
      else $error("complement wrong");
   a_daa_flags: assert property (tk && instr.op == decimal_adjust_op |=>
      mem_we && flags[3:1] == $past(flags[3:1])) else $error("decimal adjust touched flags");
   a_sbc_borrow: assert property (tk && instr.op == subtract_borrow_op |=> flags.carry_flag ==
      ({1'b0, $past(working_register)} >= {1'b0, $past(instr.mem_data)} + 9'(!$past(flags.carry_flag))))
      else $error("borrow carry wrong");
   a_idle_step: assert property (tk && instr.op == idle_op |=>
      pc == $past(pc) + PC_STEP && $stable(working_register) && !mem_we) else $error("idle changed state");
   c_jump: cover property (tk && instr.op == jump_op);
   c_wake: cover property (sys_clk_gate_off ##1 !sys_clk_gate_off);
   c_irq: cover property (irq_vector_take);
endmodule
bind mcu_instruction_execute_datapath exec_checker #(.DW(DW)) chk_u (.sys_clk(sys_clk), .nrst(nrst),
   .instr_valid(instr_valid), .instr(instr), .stack_top(stack_top), .irq_pending(irq_pending), .wake(wake),
   .working_register(working_register), .mem_we(mem_we), .flags(flags), .pc(pc), .stack_pop(stack_pop),
   .master_interrupt_enable(master_interrupt_enable), .power_down_flag(power_down_flag),
   .watchdog_timeout_flag(watchdog_timeout_flag), .watchdog_clear(watchdog_clear),
   .sys_clk_gate_off(sys_clk_gate_off), .dummy_cycle(dummy_cycle), .irq_vector_take(irq_vector_take));
`default_nettype wire

// >>> bench/testbench.sv
// Testbench: instruction sequences against a reference of each operation
`default_nettype none
module testbench
   import exec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 0, nrst = 0, instr_valid = 0, irq_pending = 0, wake = 0;
   instr_t instr = '0;
   logic [PC_W-1:0] stack_top = 11'h2A5, pc, epc = 11'h000;
   logic [7:0] working_register, mem_wdata, ew = 8'h00, ewd;
   flags_t flags, ef = FLAGS_RESET;
   logic mem_we, stack_pop, master_interrupt_enable, power_down_flag, watchdog_timeout_flag, watchdog_clear;
   logic sys_clk_gate_off, dummy_cycle, irq_vector_take, emie = 0, epdf = 0;
   int err_total = 0, checks_done = 0, cyc = 0;
   op_t rot[8] = '{rotate_left_op, rotate_left_to_w_op, rotate_left_carry_op, rotate_left_carry_to_w_op,
      rotate_right_op, rotate_right_to_w_op, rotate_right_carry_op, rotate_right_carry_to_w_op};
   logic [15:0] sbc_t[4] = '{16'h5522, 16'h0001, 16'h8001, 16'h0505};
   logic [15:0] daa_t[4] = '{16'h1516, 16'h1BFF, 16'hA3FF, 16'h1200};

   mcu_instruction_execute_datapath dut_u (.sys_clk(sys_clk), .nrst(nrst), .instr_valid(instr_valid),
      .instr(instr), .stack_top(stack_top), .irq_pending(irq_pending), .wake(wake),
      .working_register(working_register), .mem_wdata(mem_wdata), .mem_we(mem_we), .flags(flags), .pc(pc),
      .stack_pop(stack_pop), .master_interrupt_enable(master_interrupt_enable), .power_down_flag(power_down_flag),
      .watchdog_timeout_flag(watchdog_timeout_flag), .watchdog_clear(watchdog_clear),
      .sys_clk_gate_off(sys_clk_gate_off), .dummy_cycle(dummy_cycle), .irq_vector_take(irq_vector_take));

   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      checks_done++;
      if (s !== e)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask

   // Called at a falling edge; mirrors one instruction and compares the outputs, pc only when pck is set and write data only when wm is set
   task automatic run(input op_t op, input logic [7:0] m, input logic [7:0] x = 8'h00,
      input logic [PC_W-1:0] a = 11'h000);
      logic [7:0] r;
      logic [8:0] s, d;
      logic [4:0] l;
      logic z, wm, dm, pck, lo, hi;
      flags_t sf;
      {r, z, wm, dm, pck} = {ew, 4'b0001};
      epc = epc + PC_STEP;
      lo = ew[3:0] > NIB_LIMIT || ef.aux_carry_flag;
      hi = ew[7:4] > NIB_LIMIT || ef.carry_flag;
      d = {1'b0, ew} + (lo ? {1'b0, ADJ_LOW} : 9'h000) + (hi ? {1'b0, ADJ_HIGH} : 9'h000);
      s = {1'b0, ew} - {1'b0, m} - 9'(!ef.carry_flag);
      l = {1'b0, ew[3:0]} - {1'b0, m[3:0]} - 5'(!ef.carry_flag);
      // Signed overflow is judged on the full result, borrow included
      sf = {(ew[7] ^ m[7]) & (s[7] ^ ew[7]), s[7:0] == 8'h00, !l[4], !s[8]};
      case (op)
         complement_to_w_op: {r, z} = {~m, 1'b1};
         decimal_adjust_op: {r, wm, ef.carry_flag} = {d[7:0], 1'b1, ef.carry_flag | d[8] | hi};
         add_one_op: {r, wm, z} = {m + 8'h01, 2'b11};
         add_one_to_w_op: {r, z} = {m + 8'h01, 1'b1};
         subtract_one_op: {r, wm, z} = {m - 8'h01, 2'b11};
         subtract_one_to_w_op: {r, z} = {m - 8'h01, 1'b1};
         power_down_op: epdf = 1;
         jump_op: {epc, dm} = {a, 1'b1};
         transfer_mem_to_w_op: r = m;
         transfer_w_to_mem_op: wm = 1;
         transfer_imm_to_w_op: r = x;
         or_mem_to_w_op: {r, z} = {ew | m, 1'b1};
         or_imm_to_w_op: {r, z} = {ew | x, 1'b1};
         or_to_memory_op: {r, wm, z} = {ew | m, 2'b11};
         subroutine_exit_op: {epc, dm} = {stack_top, 1'b1};
         subroutine_exit_imm_op: {epc, dm, r} = {stack_top, 1'b1, x};
         interrupt_exit_op: {epc, dm, emie, pck} = {stack_top, 2'b11, !irq_pending};
         rotate_left_op: {r, wm} = {m[6:0], m[7], 1'b1};
         rotate_left_to_w_op: r = {m[6:0], m[7]};
         rotate_left_carry_op: {r, wm, ef.carry_flag} = {m[6:0], ef.carry_flag, 1'b1, m[7]};
         rotate_left_carry_to_w_op: {r, ef.carry_flag} = {m[6:0], ef.carry_flag, m[7]};
         rotate_right_op: {r, wm} = {m[0], m[7:1], 1'b1};
         rotate_right_to_w_op: r = {m[0], m[7:1]};
         rotate_right_carry_op: {r, wm, ef.carry_flag} = {ef.carry_flag, m[7:1], 1'b1, m[0]};
         rotate_right_carry_to_w_op: {r, ef.carry_flag} = {ef.carry_flag, m[7:1], m[0]};
         subtract_borrow_op: {r, ef} = {s[7:0], sf};
         subtract_borrow_to_mem_op: {r, wm, ef} = {s[7:0], 1'b1, sf};
         decrement_skip_zero_op: {r, wm, dm, pck} = {m - 8'h01, 1'b1, m == 8'h01, m != 8'h01};
         default: r = ew;
      endcase
      if (z)
         ef.zero_flag = r == 8'h00;
      if (wm)
         ewd = r;
      else
         ew = r;
      instr = '{op: op, mem_data: m, imm: x, addr: a};
      instr_valid = 1;
      @(negedge sys_clk);
      // A different instruction offered in the dummy slot must be refused
      // Valid stays up between calls so no signal is driven twice in one step
      if (dm)
         instr = '{op: transfer_imm_to_w_op, mem_data: 8'h00, imm: ~ew, addr: 11'h000};
      chk("w", 16'(working_register), 16'(ew));
      chk("flags", 16'(flags), 16'(ef));
      if (pck)
         chk("pc", 16'(pc), 16'(epc));
      chk("we", 16'(mem_we), 16'(wm));
      if (wm)
         chk("wdata", 16'(mem_wdata), 16'(ewd));
      chk("dummy", 16'(dummy_cycle), 16'(dm));
      chk("pop", 16'(stack_pop),
         16'(op inside {subroutine_exit_op, subroutine_exit_imm_op, interrupt_exit_op}));
      chk("mie", 16'(master_interrupt_enable), 16'(emie));
      chk("vec", 16'(irq_vector_take), 16'(op == interrupt_exit_op && irq_pending));
      chk("pdf", 16'(power_down_flag), 16'(epdf));
      chk("gate", 16'({sys_clk_gate_off, watchdog_clear, watchdog_timeout_flag}),
         16'(op == power_down_op ? 6 : 0));
      if (dm)
      begin
         @(negedge sys_clk);
         chk("dummy end", 16'({dummy_cycle, working_register}), 16'({1'b0, ew}));
      end
   endtask

   initial
   begin
      forever #5 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_total++;
         summarize();
      end
   end

   initial
   begin
      repeat (3) @(negedge sys_clk);
      nrst = 1;
      run(transfer_w_to_mem_op, 8'h00);
      run(transfer_imm_to_w_op, 8'h00, 8'hF0);
      run(or_mem_to_w_op, 8'h0F);
      run(or_imm_to_w_op, 8'h00, 8'h00);
      run(or_to_memory_op, 8'h00);
      run(complement_to_w_op, 8'hFF);
      run(add_one_op, 8'hFF);
      run(subtract_one_op, 8'h00);
      run(add_one_to_w_op, 8'h7F);
      run(subtract_one_to_w_op, 8'h01);
      run(idle_op, 8'h00);
      run(transfer_mem_to_w_op, 8'hC3);
      foreach (rot[i])
      begin
         run(rot[i], 8'h81);
         run(rot[i], 8'h42);
      end
      foreach (sbc_t[i])
      begin
         run(transfer_imm_to_w_op, 8'h00, sbc_t[i][15:8]);
         run(subtract_borrow_op, sbc_t[i][7:0]);
         run(transfer_imm_to_w_op, 8'h00, sbc_t[i][15:8]);
         run(subtract_borrow_to_mem_op, sbc_t[i][7:0]);
      end
      foreach (daa_t[i])
      begin
         run(transfer_imm_to_w_op, 8'h00, daa_t[i][15:8]);
         run(subtract_borrow_to_mem_op, daa_t[i][7:0]);
         run(decimal_adjust_op, 8'h00);
      end
      run(jump_op, 8'h00, 8'h00, 11'h123);
      run(subroutine_exit_op, 8'h00);
      run(subroutine_exit_imm_op, 8'h00, 8'h3C);
      run(interrupt_exit_op, 8'h00);
      irq_pending = 1;
      run(interrupt_exit_op, 8'h00);
      irq_pending = 0;
      run(jump_op, 8'h00, 8'h00, 11'h040);
      run(decrement_skip_zero_op, 8'h05);
      run(decrement_skip_zero_op, 8'h01);
      run(jump_op, 8'h00, 8'h00, 11'h7FF);
      run(power_down_op, 8'h00);
      instr = '{op: transfer_imm_to_w_op, mem_data: 8'h00, imm: 8'h99, addr: 11'h000};
      instr_valid = 1;
      @(negedge sys_clk);
      chk("halt hold", 16'({pc, working_register[3:0]}), 16'({epc, ew[3:0]}));
      {instr_valid, wake} = 2'b01;
      @(negedge sys_clk);
      wake = 0;
      chk("wake", 16'(sys_clk_gate_off), 16'h0000);
      run(idle_op, 8'h00);
      summarize();
   end
endmodule
`default_nettype wire

// >>> hdl/exec_pkg.sv
// Package: opcodes, flag layout and width and value constants for the execute datapath
`default_nettype none
package exec_pkg;
   localparam int DATA_W = 8;
   localparam int PC_W = 11;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_ONE = 8'h01;
   localparam logic [3:0] NIB_LIMIT = 4'h9;
   localparam logic [7:0] ADJ_LOW = 8'h06;
   localparam logic [7:0] ADJ_HIGH = 8'h60;
   localparam logic [PC_W-1:0] PC_STEP = 11'h001;
   localparam logic [PC_W-1:0] PC_RESET = 11'h000;
   localparam int MSB = 7;

   typedef enum logic [4:0] {
      idle_op,
      complement_to_w_op,
      decimal_adjust_op,
      add_one_op,
      add_one_to_w_op,
      subtract_one_op,
      subtract_one_to_w_op,
      power_down_op,
      jump_op,
      transfer_mem_to_w_op,
      transfer_w_to_mem_op,
      transfer_imm_to_w_op,
      or_mem_to_w_op,
      or_imm_to_w_op,
      or_to_memory_op,
      subroutine_exit_op,
      subroutine_exit_imm_op,
      interrupt_exit_op,
      rotate_left_op,
      rotate_left_to_w_op,
      rotate_left_carry_op,
      rotate_left_carry_to_w_op,
      rotate_right_op,
      rotate_right_to_w_op,
      rotate_right_carry_op,
      rotate_right_carry_to_w_op,
      subtract_borrow_op,
      subtract_borrow_to_mem_op,
      decrement_skip_zero_op
   } op_t;

   typedef struct packed {
      logic overflow_flag;
      logic zero_flag;
      logic aux_carry_flag;
      logic carry_flag;
   } flags_t;

   typedef struct packed {
      op_t op;
      logic [DATA_W-1:0] mem_data;
      logic [DATA_W-1:0] imm;
      logic [PC_W-1:0] addr;
   } instr_t;

   localparam flags_t FLAGS_RESET = '{overflow_flag: 1'b0, zero_flag: 1'b0, aux_carry_flag: 1'b0, carry_flag: 1'b0};
endpackage
`default_nettype wire

// >>> hdl/mcu_instruction_execute_datapath.sv
// Execute datapath: one instruction per cycle, with dummy cycles for branches
// -----------------------------------------------------------------------------
// Notes on behaviour
// - Complement byte into working register, zero flag
// - Low nibble over nine or aux: add six
// - High nibble over nine or carry: add six
// - Decimal adjust changes carry only
// - In-place add/subtract one, zero flag only
// - Working-register add/subtract one keeps byte
// - Power-down halts, clears watchdog, sets power-down flag, clears timeout flag
// - Jump loads address, two cycles
// - Transfers change no flag
// - Idle only advances program counter
// - OR into register or byte, zero flag
// - Subroutine exit pops program counter
// - Exit with immediate also loads register
// - Interrupt exit pops and enables interrupts
// - Pending interrupt serviced before main program
// - Rotate left: bit seven into bit zero
// - Rotate left through carry, carry only
// - Rotate right: bit zero into bit seven
// - Rotate right through carry, carry only
// - Register rotates leave source byte unchanged
// - Subtract with borrow updates four flags
// - Carry is inverted borrow
// - Decrement skip zero: two cycles on zero
// -----------------------------------------------------------------------------
`default_nettype none
module mcu_instruction_execute_datapath
   import exec_pkg::*;
#(
   parameter int DW = DATA_W
)
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic instr_valid,
   input wire instr_t instr,
   input wire logic [PC_W-1:0] stack_top,
   input wire logic irq_pending,
   input wire logic wake,
   output logic [DW-1:0] working_register,
   output logic [DW-1:0] mem_wdata,
   output logic mem_we,
   output flags_t flags,
   output logic [PC_W-1:0] pc,
   output logic stack_pop,
   output logic master_interrupt_enable,
   output logic power_down_flag,
   output logic watchdog_timeout_flag,
   output logic watchdog_clear,
   output logic sys_clk_gate_off,
   output logic dummy_cycle,
   output logic irq_vector_take
);

   // ---------------------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------------------
   function automatic logic is_zero(input logic [DW-1:0] v);
      return v == BYTE_ZERO;
   endfunction

   // ---------------------------------------------------------------------------
   // State
   // ---------------------------------------------------------------------------
   logic [DW-1:0] w_r, w_nxt;
   logic [DW-1:0] wd_r, wd_nxt;
   logic we_r, we_nxt;
   flags_t fl_r, fl_nxt;
   logic [PC_W-1:0] pc_r, pc_nxt;
   logic pop_r, pop_nxt;
   logic emi_r, emi_nxt;
   logic pdf_r, pdf_nxt;
   logic to_r, to_nxt;
   logic wdc_r, wdc_nxt;
   logic halt_r, halt_nxt;
   logic dummy_r, dummy_nxt;
   logic irq_r, irq_nxt;

   // ---------------------------------------------------------------------------
   // Next-state computation
   // ---------------------------------------------------------------------------
   always_comb
   begin
      logic [DW-1:0] m;
      logic [DW-1:0] res;
      logic [DW-1:0] adj;
      logic [DW:0] sum;
      logic [4:0] lo;
      logic [DW:0] sdiff;
      logic bin;
      m = instr.mem_data;
      res = BYTE_ZERO;
      adj = BYTE_ZERO;
      sum = '0;
      lo = '0;
      sdiff = '0;
      bin = 1'b0;
      w_nxt = w_r;
      wd_nxt = wd_r;
      we_nxt = 1'b0;
      fl_nxt = fl_r;
      pc_nxt = pc_r;
      pop_nxt = 1'b0;
      emi_nxt = emi_r;
      pdf_nxt = pdf_r;
      to_nxt = to_r;
      wdc_nxt = 1'b0;
      halt_nxt = halt_r;
      dummy_nxt = 1'b0;
      irq_nxt = 1'b0;
      if (halt_r)
      begin
         // Registers hold while the core clock is gated; only wake resumes
         if (wake)
            halt_nxt = 1'b0;
      end
      else if (dummy_r)
      begin
         // Dummy cycle: fetch slot of the branch, nothing executes
         dummy_nxt = 1'b0;
      end
      else if (instr_valid)
      begin
         pc_nxt = pc_r + PC_STEP;
         unique case (instr.op)
            idle_op:
            begin
               // Nothing besides the program counter step
            end
            complement_to_w_op:
            begin
               res = ~m;
               w_nxt = res;
               fl_nxt.zero_flag = is_zero(res);
            end
            decimal_adjust_op:
            begin
               if (w_r[3:0] > NIB_LIMIT || fl_r.aux_carry_flag)
                  adj = adj | ADJ_LOW;
               if (w_r[7:4] > NIB_LIMIT || fl_r.carry_flag)
                  adj = adj | ADJ_HIGH;
               sum = {1'b0, w_r} + {1'b0, adj};
               wd_nxt = sum[DW-1:0];
               we_nxt = 1'b1;
               // Carry is only ever set here, so a chained decimal add keeps it
               fl_nxt.carry_flag = fl_r.carry_flag | sum[DW] | adj[4];
            end
            add_one_op, subtract_one_op:
            begin
               res = (instr.op == add_one_op) ? m + BYTE_ONE : m - BYTE_ONE;
               wd_nxt = res;
               we_nxt = 1'b1;
               fl_nxt.zero_flag = is_zero(res);
            end
            add_one_to_w_op, subtract_one_to_w_op:
            begin
               res = (instr.op == add_one_to_w_op) ? m + BYTE_ONE : m - BYTE_ONE;
               w_nxt = res;
               fl_nxt.zero_flag = is_zero(res);
            end
            power_down_op:
            begin
               halt_nxt = 1'b1;
               wdc_nxt = 1'b1;
               pdf_nxt = 1'b1;
               to_nxt = 1'b0;
            end
            jump_op:
            begin
               pc_nxt = instr.addr;
               dummy_nxt = 1'b1;
            end
            transfer_mem_to_w_op:
               w_nxt = m;
            transfer_imm_to_w_op:
               w_nxt = instr.imm;
            transfer_w_to_mem_op:
            begin
               wd_nxt = w_r;
               we_nxt = 1'b1;
            end
            or_mem_to_w_op, or_imm_to_w_op, or_to_memory_op:
            begin
               res = w_r | ((instr.op == or_imm_to_w_op) ? instr.imm : m);
               if (instr.op == or_to_memory_op)
               begin
                  wd_nxt = res;
                  we_nxt = 1'b1;
               end
               else
                  w_nxt = res;
               fl_nxt.zero_flag = is_zero(res);
            end
            subroutine_exit_op, subroutine_exit_imm_op, interrupt_exit_op:
            begin
               pc_nxt = stack_top;
               pop_nxt = 1'b1;
               dummy_nxt = 1'b1;
               if (instr.op == subroutine_exit_imm_op)
                  w_nxt = instr.imm;
               if (instr.op == interrupt_exit_op)
               begin
                  emi_nxt = 1'b1;
                  // Pending request goes to its vector before the main program resumes
                  irq_nxt = irq_pending;
               end
            end
            rotate_left_op, rotate_left_to_w_op:
            begin
               res = {m[DW-2:0], m[MSB]};
               if (instr.op == rotate_left_to_w_op)
                  w_nxt = res;
               else
               begin
                  wd_nxt = res;
                  we_nxt = 1'b1;
               end
            end
            rotate_left_carry_op, rotate_left_carry_to_w_op:
            begin
               res = {m[DW-2:0], fl_r.carry_flag};
               fl_nxt.carry_flag = m[MSB];
               if (instr.op == rotate_left_carry_to_w_op)
                  w_nxt = res;
               else
               begin
                  wd_nxt = res;
                  we_nxt = 1'b1;
               end
            end
            rotate_right_op, rotate_right_to_w_op:
            begin
               res = {m[0], m[DW-1:1]};
               if (instr.op == rotate_right_to_w_op)
                  w_nxt = res;
               else
               begin
                  wd_nxt = res;
                  we_nxt = 1'b1;
               end
            end
            rotate_right_carry_op, rotate_right_carry_to_w_op:
            begin
               res = {fl_r.carry_flag, m[DW-1:1]};
               fl_nxt.carry_flag = m[0];
               if (instr.op == rotate_right_carry_to_w_op)
                  w_nxt = res;
               else
               begin
                  wd_nxt = res;
                  we_nxt = 1'b1;
               end
            end
            subtract_borrow_op, subtract_borrow_to_mem_op:
            begin
               bin = ~fl_r.carry_flag;
               sdiff = {1'b0, w_r} - {1'b0, m} - {{DW{1'b0}}, bin};
               lo = {1'b0, w_r[3:0]} - {1'b0, m[3:0]} - {4'h0, bin};
               res = sdiff[DW-1:0];
               fl_nxt.carry_flag = ~sdiff[DW];
               fl_nxt.aux_carry_flag = ~lo[4];
               fl_nxt.overflow_flag = (w_r[MSB] ^ m[MSB]) & (w_r[MSB] ^ res[MSB]);
               fl_nxt.zero_flag = is_zero(res);
               if (instr.op == subtract_borrow_to_mem_op)
               begin
                  wd_nxt = res;
                  we_nxt = 1'b1;
               end
               else
                  w_nxt = res;
            end
            decrement_skip_zero_op:
            begin
               res = m - BYTE_ONE;
               wd_nxt = res;
               we_nxt = 1'b1;
               dummy_nxt = is_zero(res);
            end
         endcase
      end
   end

   // ---------------------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------------------
   // All results land in one edge so the next instruction sees them
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         w_r <= BYTE_ZERO;
         wd_r <= BYTE_ZERO;
         we_r <= 1'b0;
         fl_r <= FLAGS_RESET;
         pc_r <= PC_RESET;
         pop_r <= 1'b0;
         emi_r <= 1'b0;
         pdf_r <= 1'b0;
         to_r <= 1'b0;
         wdc_r <= 1'b0;
         halt_r <= 1'b0;
         dummy_r <= 1'b0;
         irq_r <= 1'b0;
      end
      else
      begin
         w_r <= w_nxt;
         wd_r <= wd_nxt;
         we_r <= we_nxt;
         fl_r <= fl_nxt;
         pc_r <= pc_nxt;
         pop_r <= pop_nxt;
         emi_r <= emi_nxt;
         pdf_r <= pdf_nxt;
         to_r <= to_nxt;
         wdc_r <= wdc_nxt;
         halt_r <= halt_nxt;
         dummy_r <= dummy_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign working_register = w_r;
   assign mem_wdata = wd_r;
   assign mem_we = we_r;
   assign flags = fl_r;
   assign pc = pc_r;
   assign stack_pop = pop_r;
   assign master_interrupt_enable = emi_r;
   assign power_down_flag = pdf_r;
   assign watchdog_timeout_flag = to_r;
   assign watchdog_clear = wdc_r;
   assign sys_clk_gate_off = halt_r;
   assign dummy_cycle = dummy_r;
   assign irq_vector_take = irq_r;

endmodule
`default_nettype wire
